/* design/bridge_router_defs.svh */
`ifndef BRIDGE_ROUTER_DEFS_SVH
`define BRIDGE_ROUTER_DEFS_SVH

// ----------------------------------------------------------------------
// bus command codes, sampled on the command lines in the address phase
// ----------------------------------------------------------------------
`define CMD_INT_ACK 4'h0
`define CMD_SPECIAL 4'h1
`define CMD_IO_READ 4'h2
`define CMD_IO_WRITE 4'h3
`define CMD_RSVD_4 4'h4
`define CMD_RSVD_5 4'h5
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define CMD_RSVD_8 4'h8
`define CMD_RSVD_9 4'h9
`define CMD_CFG_READ 4'hA
`define CMD_CFG_WRITE 4'hB
`define CMD_MEM_READ_MULT 4'hC
`define CMD_MEM_WRITE_MULT 4'hD
`define CMD_MEM_READ_LINE 4'hE
`define CMD_MEM_WRITE_INV 4'hF

// ----------------------------------------------------------------------
// configuration address layout
// ----------------------------------------------------------------------
`define CFG_BUS_HI 23
`define CFG_BUS_LO 16
`define CFG_DEV_HI 15
`define CFG_DEV_LO 11
`define CFG_FUNC_HI 10
`define CFG_FUNC_LO 8
`define CFG_REG_HI 7
`define CFG_REG_LO 2
`define CFG_TYPE0_CODE 2'h0
`define CFG_TYPE1_CODE 2'h1
`define IDSEL_LO 16
`define IDSEL_DEV_LIMIT 5'h10
`define SPECIAL_DEV 5'h1F
`define SPECIAL_FUNC 3'h7
`define OWN_FUNC 3'h0

// ----------------------------------------------------------------------
// timing and reset values
// ----------------------------------------------------------------------
`define DEVSEL_CLOCKS 2'h2
`define BUS_NUM_RESET 8'h00
`define ALL_BYTES 4'hF
`define ADDR_ZERO 32'h0000_0000

`endif

/* design/bridge_router_pkg.sv */
package bridge_router_pkg;

  // ----------------------------------------------------------------------
  // what a claimed transaction will do
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    act_none,
    act_header,
    act_to_type0,
    act_pass_type1,
    act_special,
    act_pass_mem
  } action_e;

  // per-bus target side state
  typedef struct packed {
    logic [1:0] cnt;
    logic devsel;
    logic first;
    logic write;
    action_e act;
    logic [3:0] cmd;
    logic [31:0] addr;
  } side_s;

  // whole state of the router
  typedef struct packed {
    side_s up;
    side_s dn;
    logic [7:0] pri_bus;
    logic [7:0] sec_bus;
    logic [7:0] sub_bus;
    logic up_stop;
    logic dn_stop;
    logic hdr_valid;
    logic hdr_write;
    logic [5:0] hdr_reg;
    logic [3:0] hdr_be;
    logic [31:0] hdr_wdata;
    logic dfwd_valid;
    logic [3:0] dfwd_cmd;
    logic [31:0] dfwd_addr;
    logic [31:0] dfwd_data;
    logic ufwd_valid;
    logic [3:0] ufwd_cmd;
    logic [31:0] ufwd_addr;
    logic [31:0] ufwd_data;
  } router_s;

endpackage : bridge_router_pkg

/* design/cfg_addr_decoder.sv */
`include "bridge_router_defs.svh"

module cfg_addr_decoder (
  input wire logic [31:0] ad,
  output logic is_type0,
  output logic is_type1,
  output logic [7:0] bus_num,
  output logic [4:0] dev_num,
  output logic [2:0] func_num,
  output logic [5:0] reg_num,
  output logic special_req,
  output logic [31:0] type0_addr
);

  // ----------------------------------------------------------------------
  // field split of a configuration address
  // ----------------------------------------------------------------------
  logic [15:0] idsel;

  assign is_type0 = (ad[1:0] == `CFG_TYPE0_CODE);
  assign is_type1 = (ad[1:0] == `CFG_TYPE1_CODE);
  assign bus_num = ad[`CFG_BUS_HI:`CFG_BUS_LO];
  assign dev_num = ad[`CFG_DEV_HI:`CFG_DEV_LO];
  assign func_num = ad[`CFG_FUNC_HI:`CFG_FUNC_LO];
  assign reg_num = ad[`CFG_REG_HI:`CFG_REG_LO];
  assign special_req = (dev_num == `SPECIAL_DEV) &&
                       (func_num == `SPECIAL_FUNC);

  // one-hot select line, devices 10h and up select nothing
  always_comb begin
    idsel = 16'h0000;
    if (dev_num < `IDSEL_DEV_LIMIT) begin
      idsel[dev_num[3:0]] = 1'b1;
    end
  end

  // converted address: select lines, fields kept, low bits 00
  assign type0_addr = {idsel, ad[`CFG_DEV_HI:`CFG_REG_LO], `CFG_TYPE0_CODE};

endmodule : cfg_addr_decoder

/* design/pci_bridge_config_cycle_router.sv */
// Notes on behaviour
// - never issue or claim interrupt-acknowledge or reserved commands
// - never claim special cycles; issue them only from type 1 requests
// - no type 0 upstream issue; never claim downstream type 0 accesses
// - claimed accesses raise device select two clocks after address phase
// - write-and-invalidate becomes memory write unless full line is assured
// - upstream claims inside windows; downstream claims outside windows
// - type 1 fields: bus 23:16, device 15:11, function 10:8, low 01
// - register field picks a doubleword; byte enables pick its bytes
// - type 0 claimed only with select asserted and function 0
// - configuration accesses are one doubleword; disconnect on first data
// - header reads have no side effect and return all four bytes
// - type 1 to the secondary bus becomes downstream type 0
// - conversion drives low address bits 00, keeps other fields
// - device n below 10h drives select bit 16+n, others none
// - type 1 above secondary, up to subordinate, passes downstream unchanged
// - special request to secondary bus makes a downstream special cycle
// - special request to a deeper bus passes downstream as type 1
// - downstream special request to primary bus makes upstream special cycle
// - special cycles never cross; only type 1 requests propagate
// - configuration read is 1010, configuration write is 1011
// - special cycle command is 0001
`include "bridge_router_defs.svh"

module pci_bridge_config_cycle_router
  import bridge_router_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bus_num_load,
  input wire logic [7:0] primary_bus_in,
  input wire logic [7:0] secondary_bus_in,
  input wire logic [7:0] subordinate_bus_in,
  input wire logic up_addr_phase,
  input wire logic [31:0] up_addr_data,
  input wire logic [3:0] upstream_cmd_byte_enable,
  input wire logic upstream_config_select,
  input wire logic up_window_hit,
  input wire logic up_line_ok,
  input wire logic up_data_valid,
  input wire logic up_data_last,
  input wire logic dn_addr_phase,
  input wire logic [31:0] dn_addr_data,
  input wire logic [3:0] dn_cmd_byte_enable,
  input wire logic dn_window_hit,
  input wire logic dn_line_ok,
  input wire logic dn_data_valid,
  input wire logic dn_data_last,
  output logic upstream_device_select,
  output logic up_stop,
  output logic downstream_device_select,
  output logic dn_stop,
  output logic hdr_valid,
  output logic hdr_write,
  output logic [5:0] hdr_reg_index,
  output logic [3:0] hdr_byte_enable,
  output logic [31:0] hdr_wdata,
  output logic dn_fwd_valid,
  output logic [3:0] dn_fwd_cmd,
  output logic [31:0] dn_fwd_addr,
  output logic [31:0] dn_fwd_data,
  output logic up_fwd_valid,
  output logic [3:0] up_fwd_cmd,
  output logic [31:0] up_fwd_addr,
  output logic [31:0] up_fwd_data
);

  // ----------------------------------------------------------------------
  // command class helpers
  // ----------------------------------------------------------------------
  function automatic logic cmd_ignored(input logic [3:0] cmd);
    cmd_ignored = (cmd == `CMD_INT_ACK) || (cmd == `CMD_RSVD_4) ||
                  (cmd == `CMD_RSVD_5) || (cmd == `CMD_RSVD_8) ||
                  (cmd == `CMD_RSVD_9);
  endfunction : cmd_ignored

  function automatic logic cmd_is_cfg(input logic [3:0] cmd);
    cmd_is_cfg = (cmd == `CMD_CFG_READ) || (cmd == `CMD_CFG_WRITE);
  endfunction : cmd_is_cfg

  function automatic logic cmd_is_mem_io(input logic [3:0] cmd);
    cmd_is_mem_io = !cmd_ignored(cmd) && !cmd_is_cfg(cmd) &&
                    (cmd != `CMD_SPECIAL);
  endfunction : cmd_is_mem_io

  // command sent on the far bus for a memory or i/o access
  function automatic logic [3:0] fwd_cmd(input logic [3:0] cmd,
                                         input logic line_ok);
    if ((cmd == `CMD_MEM_WRITE_INV) && !line_ok) begin
      fwd_cmd = `CMD_MEM_WRITE;
    end else begin
      fwd_cmd = cmd;
    end
  endfunction : fwd_cmd

  // device select counting, shared by both buses
  function automatic side_s side_claim(input side_s cur, input action_e act,
                                       input logic [3:0] cmd,
                                       input logic [31:0] addr,
                                       input logic write);
    side_claim = cur;
    side_claim.act = act;
    side_claim.cmd = cmd;
    side_claim.addr = addr;
    side_claim.write = write;
    side_claim.first = 1'b1;
    side_claim.cnt = `DEVSEL_CLOCKS - 2'h1;
  endfunction : side_claim

  function automatic side_s side_tick(input side_s cur);
    side_tick = cur;
    if (cur.cnt != 2'h0) begin
      side_tick.cnt = cur.cnt - 2'h1;
      side_tick.devsel = (cur.cnt == 2'h1);
    end
  endfunction : side_tick

  // ----------------------------------------------------------------------
  // reset release and state
  // ----------------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;
  router_s st_ff;
  router_s nxt_st;

  // two-stage release of the asynchronous reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------------
  // address field decode of both buses
  // ----------------------------------------------------------------------
  logic u_t0;
  logic u_t1;
  logic [7:0] u_bus;
  logic [2:0] u_func;
  logic [5:0] u_reg;
  logic u_spec;
  logic [31:0] u_conv;
  logic d_t1;
  logic [7:0] d_bus;
  logic d_spec;

  cfg_addr_decoder up_dec (
    .ad(up_addr_data),
    .is_type0(u_t0),
    .is_type1(u_t1),
    .bus_num(u_bus),
    .dev_num(),
    .func_num(u_func),
    .reg_num(u_reg),
    .special_req(u_spec),
    .type0_addr(u_conv)
  );

  cfg_addr_decoder dn_dec (
    .ad(dn_addr_data),
    .is_type0(),
    .is_type1(d_t1),
    .bus_num(d_bus),
    .dev_num(),
    .func_num(),
    .reg_num(),
    .special_req(d_spec),
    .type0_addr()
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic u_cmd_wr;
    logic d_cmd_wr;
    logic u_go;
    logic d_go;
    u_cmd_wr = (upstream_cmd_byte_enable == `CMD_CFG_WRITE);
    d_cmd_wr = (dn_cmd_byte_enable == `CMD_CFG_WRITE);
    u_go = st_ff.up.devsel && up_data_valid;
    d_go = st_ff.dn.devsel && dn_data_valid;
    nxt_st = st_ff;
    nxt_st.up = side_tick(st_ff.up);
    nxt_st.dn = side_tick(st_ff.dn);
    nxt_st.up_stop = 1'b0;
    nxt_st.dn_stop = 1'b0;
    nxt_st.hdr_valid = 1'b0;
    nxt_st.dfwd_valid = 1'b0;
    nxt_st.ufwd_valid = 1'b0;

    // bus numbers loaded by configuration software
    if (bus_num_load) begin
      nxt_st.pri_bus = primary_bus_in;
      nxt_st.sec_bus = secondary_bus_in;
      nxt_st.sub_bus = subordinate_bus_in;
    end

    // upstream address phase, taken only while idle
    if (up_addr_phase && (st_ff.up.act == act_none)) begin
      if (cmd_is_mem_io(upstream_cmd_byte_enable)) begin
        if (up_window_hit) begin
          nxt_st.up = side_claim(st_ff.up, act_pass_mem,
                                 fwd_cmd(upstream_cmd_byte_enable,
                                         up_line_ok),
                                 up_addr_data, 1'b0);
        end
      end else if (cmd_is_cfg(upstream_cmd_byte_enable)) begin
        if (u_t0 && upstream_config_select &&
            (u_func == `OWN_FUNC)) begin
          nxt_st.up = side_claim(st_ff.up, act_header,
                                 upstream_cmd_byte_enable, up_addr_data,
                                 u_cmd_wr);
        end else if (u_t1 && (u_bus == st_ff.sec_bus)) begin
          if (u_spec && u_cmd_wr) begin
            nxt_st.up = side_claim(st_ff.up, act_special, `CMD_SPECIAL,
                                   `ADDR_ZERO, 1'b1);
          end else begin
            nxt_st.up = side_claim(st_ff.up, act_to_type0,
                                   upstream_cmd_byte_enable, u_conv,
                                   u_cmd_wr);
          end
        end else if (u_t1 && (u_bus > st_ff.sec_bus) &&
                     (u_bus <= st_ff.sub_bus)) begin
          nxt_st.up = side_claim(st_ff.up, act_pass_type1,
                                 upstream_cmd_byte_enable, up_addr_data,
                                 u_cmd_wr);
        end
      end
    end

    // downstream address phase, subtractive and special requests only
    if (dn_addr_phase && (st_ff.dn.act == act_none)) begin
      if (cmd_is_mem_io(dn_cmd_byte_enable)) begin
        if (!dn_window_hit) begin
          nxt_st.dn = side_claim(st_ff.dn, act_pass_mem,
                                 fwd_cmd(dn_cmd_byte_enable, dn_line_ok),
                                 dn_addr_data, 1'b0);
        end
      end else if (d_cmd_wr && d_t1 && d_spec &&
                   (d_bus == st_ff.pri_bus)) begin
        nxt_st.dn = side_claim(st_ff.dn, act_special, `CMD_SPECIAL,
                               `ADDR_ZERO, 1'b1);
      end
    end

    // upstream data phase
    if (u_go) begin
      nxt_st.up.first = 1'b0;
      if (st_ff.up.act == act_header) begin
        nxt_st.hdr_valid = 1'b1;
        nxt_st.hdr_write = st_ff.up.write;
        nxt_st.hdr_reg = st_ff.up.addr[`CFG_REG_HI:`CFG_REG_LO];
        nxt_st.hdr_be = st_ff.up.write ? upstream_cmd_byte_enable
                                       : `ALL_BYTES;
        nxt_st.hdr_wdata = st_ff.up.write ? up_addr_data : st_ff.hdr_wdata;
      end else if (st_ff.up.first) begin
        nxt_st.dfwd_valid = 1'b1;
        nxt_st.dfwd_cmd = st_ff.up.cmd;
        nxt_st.dfwd_addr = st_ff.up.addr;
        nxt_st.dfwd_data = up_addr_data;
      end
      if (st_ff.up.act != act_pass_mem) begin
        nxt_st.up_stop = !up_data_last;
        nxt_st.up.devsel = 1'b0;
        nxt_st.up.act = act_none;
      end else if (up_data_last) begin
        nxt_st.up.devsel = 1'b0;
        nxt_st.up.act = act_none;
      end
    end

    // downstream data phase
    if (d_go) begin
      nxt_st.dn.first = 1'b0;
      if (st_ff.dn.first) begin
        nxt_st.ufwd_valid = 1'b1;
        nxt_st.ufwd_cmd = st_ff.dn.cmd;
        nxt_st.ufwd_addr = st_ff.dn.addr;
        nxt_st.ufwd_data = dn_addr_data;
      end
      if (st_ff.dn.act != act_pass_mem) begin
        nxt_st.dn_stop = !dn_data_last;
        nxt_st.dn.devsel = 1'b0;
        nxt_st.dn.act = act_none;
      end else if (dn_data_last) begin
        nxt_st.dn.devsel = 1'b0;
        nxt_st.dn.act = act_none;
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff <= '0;
      st_ff.up.act <= act_none;
      st_ff.dn.act <= act_none;
      st_ff.pri_bus <= `BUS_NUM_RESET;
      st_ff.sec_bus <= `BUS_NUM_RESET;
      st_ff.sub_bus <= `BUS_NUM_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign upstream_device_select = st_ff.up.devsel;
  assign downstream_device_select = st_ff.dn.devsel;
  assign up_stop = st_ff.up_stop;
  assign dn_stop = st_ff.dn_stop;
  assign hdr_valid = st_ff.hdr_valid;
  assign hdr_write = st_ff.hdr_write;
  assign hdr_reg_index = st_ff.hdr_reg;
  assign hdr_byte_enable = st_ff.hdr_be;
  assign hdr_wdata = st_ff.hdr_wdata;
  assign dn_fwd_valid = st_ff.dfwd_valid;
  assign dn_fwd_cmd = st_ff.dfwd_cmd;
  assign dn_fwd_addr = st_ff.dfwd_addr;
  assign dn_fwd_data = st_ff.dfwd_data;
  assign up_fwd_valid = st_ff.ufwd_valid;
  assign up_fwd_cmd = st_ff.ufwd_cmd;
  assign up_fwd_addr = st_ff.ufwd_addr;
  assign up_fwd_data = st_ff.ufwd_data;

endmodule : pci_bridge_config_cycle_router

/* tb/pci_bridge_config_cycle_router_assertions.sv */
module router_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic up_addr_phase,
  input wire logic [31:0] up_addr_data,
  input wire logic [3:0] upstream_cmd_byte_enable,
  input wire logic upstream_config_select,
  input wire logic up_window_hit,
  input wire logic up_data_valid,
  input wire logic up_data_last,
  input wire logic dn_addr_phase,
  input wire logic [31:0] dn_addr_data,
  input wire logic [3:0] dn_cmd_byte_enable,
  input wire logic dn_window_hit,
  input wire logic dn_data_valid,
  input wire logic dn_data_last,
  input wire logic dn_stop,
  input wire logic upstream_device_select,
  input wire logic up_stop,
  input wire logic downstream_device_select,
  input wire logic hdr_valid,
  input wire logic hdr_write,
  input wire logic [3:0] hdr_byte_enable,
  input wire logic dn_fwd_valid,
  input wire logic [3:0] dn_fwd_cmd,
  input wire logic [31:0] dn_fwd_addr,
  input wire logic up_fwd_valid,
  input wire logic [3:0] up_fwd_cmd,
  input wire logic [31:0] up_fwd_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [31:0] last_addr;
  logic cfg_claim;
  logic [15:0] sel_bits;
  logic [3:0] uc;
  logic [3:0] dc;
  assign uc = upstream_cmd_byte_enable;
  assign dc = dn_cmd_byte_enable;
  assign sel_bits = last_addr[15] ? 16'h0 : 16'h1 << last_addr[14:11];

  // remember address and kind of the latest upstream request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_addr <= 32'h0;
      cfg_claim <= 1'b0;
    end else if (up_addr_phase && !upstream_device_select) begin
      last_addr <= up_addr_data;
      cfg_claim <= uc[3:1] == 3'h5;
    end
  end

  // ------------
  // request steps
  // ------------
  sequence s_up_new;
    up_addr_phase && !upstream_device_select && !$past(up_addr_phase)
      && !$past(up_addr_phase, 2);
  endsequence
  sequence s_dn_new;
    dn_addr_phase && !downstream_device_select && !$past(dn_addr_phase)
      && !$past(dn_addr_phase, 2);
  endsequence
  sequence s_hdr_req;
    s_up_new ##0 (uc[3:1] == 3'h5 && up_addr_data[1:0] == 2'h0);
  endsequence
  sequence s_cfg_more;
    cfg_claim && upstream_device_select && up_data_valid && !up_data_last;
  endsequence

  a_hdr_claim:
    assert property (s_hdr_req ##0 (upstream_config_select
      && up_addr_data[10:8] == 3'h0) |-> ##2 upstream_device_select)
    else $error("header access not claimed in time");
  a_hdr_refuse:
    assert property (s_hdr_req ##0 (!upstream_config_select
      || up_addr_data[10:8] != 3'h0) |-> ##2 !upstream_device_select)
    else $error("header access claimed wrongly");
  a_cmd_ignore:
    assert property (s_up_new ##0 (uc inside {4'h0, 4'h1, 4'h4, 4'h5,
      4'h8, 4'h9}) |-> ##2 !upstream_device_select)
    else $error("ignored command claimed");
  a_dn_type0:
    assert property (s_dn_new ##0 (dc[3:1] == 3'h5
      && dn_addr_data[1:0] == 2'h0) |-> ##2 !downstream_device_select)
    else $error("downstream type 0 claimed");
  a_window_decode:
    assert property ((s_up_new ##0 (uc inside {4'h2, 4'h3, 4'h6, 4'h7,
      [4'hC:4'hF]}) |-> ##2 upstream_device_select
      == $past(up_window_hit, 2)) and (s_dn_new ##0 (dc inside {4'h2,
      4'h3, 4'h6, 4'h7, [4'hC:4'hF]}) |-> ##2 downstream_device_select
      == !$past(dn_window_hit, 2)))
    else $error("window decode wrong");
  a_cfg_stop:
    assert property (s_cfg_more |=> up_stop && !upstream_device_select)
    else $error("no disconnect on configuration access");
  a_dn_stop:
    assert property (downstream_device_select && dn_data_valid
      && !dn_data_last |=> dn_stop == (up_fwd_cmd == 4'h1))
    else $error("downstream disconnect wrong");
  a_read_bytes:
    assert property (hdr_valid && !hdr_write |-> hdr_byte_enable == 4'hF)
    else $error("header read lost bytes");
  a_idsel_map:
    assert property (dn_fwd_valid && dn_fwd_cmd[3:1] == 3'h5
      && dn_fwd_addr[1:0] == 2'h0
      |-> dn_fwd_addr == {sel_bits, last_addr[15:2], 2'h0})
    else $error("type 0 conversion wrong");
  a_fwd_cmds:
    assert property ((dn_fwd_valid |-> !(dn_fwd_cmd inside {4'h0, 4'h4,
      4'h5, 4'h8, 4'h9})) and (up_fwd_valid |-> !(up_fwd_cmd inside
      {4'h0, 4'h4, 4'h5, 4'h8, 4'h9}) && !(up_fwd_cmd[3:1] == 3'h5
      && up_fwd_addr[1:0] == 2'h0)))
    else $error("illegal command issued");
endmodule : router_assertions

bind pci_bridge_config_cycle_router router_assertions chk_i (.*);

/* tb/pci_bus_master.sv */
module pci_bus_master (
  input wire logic clock,
  input wire logic devsel,
  output logic addr_phase,
  output logic [31:0] ad,
  output logic [3:0] cbe,
  output logic cfg_sel,
  output logic hit,
  output logic line_ok,
  output logic dvalid,
  output logic dlast
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus from time zero
  initial begin
    addr_phase = 1'b0;
    ad = 32'h0;
    cbe = 4'h0;
    {cfg_sel, hit, line_ok, dvalid, dlast} = 5'h0;
  end

  // address phase, wait for a claim, then one data phase
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr,
                      input logic [31:0] data, input logic [3:0] be,
                      input logic [3:0] ctl, output logic claimed);
    claimed = 1'b0;
    @(posedge clock);
    #1;
    addr_phase = 1'b1;
    ad = addr;
    cbe = cmd;
    {cfg_sel, hit, line_ok} = ctl[3:1];
    @(posedge clock);
    #1;
    addr_phase = 1'b0;
    cfg_sel = 1'b0;
    ad = ~addr;
    for (int n = 0; n < 5 && !claimed; n++) begin
      @(posedge clock);
      claimed = (devsel === 1'b1);
    end
    if (claimed) begin
      #1;
      dvalid = 1'b1;
      dlast = !ctl[0];
      ad = data;
      cbe = be;
      @(posedge clock);
      #1;
      dvalid = 1'b0;
      ad = ~data;
      cbe = ~be;
    end
  endtask : xfer
endmodule : pci_bus_master

/* tb/pci_bridge_config_cycle_router_tb.sv */
module pci_bridge_config_cycle_router_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [3:0] cmd;
    logic [31:0] addr;
    logic [31:0] data;
    logic dchk;
  } exp_s;
  logic clock, rst_n, bus_num_load, upstream_config_select;
  logic [7:0] primary_bus_in, secondary_bus_in, subordinate_bus_in;
  logic up_addr_phase, up_window_hit, up_line_ok, up_data_valid;
  logic dn_addr_phase, dn_window_hit, dn_line_ok, dn_data_valid;
  logic up_data_last, dn_data_last, hdr_valid, hdr_write;
  logic [31:0] up_addr_data, dn_addr_data, hdr_wdata, dn_fwd_addr;
  logic [31:0] dn_fwd_data, up_fwd_addr, up_fwd_data, seed, wd, a;
  logic [3:0] upstream_cmd_byte_enable, dn_cmd_byte_enable, c;
  logic [3:0] hdr_byte_enable, dn_fwd_cmd, up_fwd_cmd;
  logic upstream_device_select, up_stop, downstream_device_select;
  logic dn_stop, dn_fwd_valid, up_fwd_valid, m, x;
  logic [5:0] hdr_reg_index;
  int num_errors, checked, cyc, i;
  exp_s dn_q[$], up_q[$], hdr_q[$];

  pci_bridge_config_cycle_router dut (.*);
  pci_bus_master up_m (.clock(clock), .devsel(upstream_device_select),
    .addr_phase(up_addr_phase), .ad(up_addr_data),
    .cbe(upstream_cmd_byte_enable), .cfg_sel(upstream_config_select),
    .hit(up_window_hit), .line_ok(up_line_ok), .dvalid(up_data_valid),
    .dlast(up_data_last));
  pci_bus_master dn_m (.clock(clock), .devsel(downstream_device_select),
    .addr_phase(dn_addr_phase), .ad(dn_addr_data),
    .cbe(dn_cmd_byte_enable), .cfg_sel(), .hit(dn_window_hit),
    .line_ok(dn_line_ok), .dvalid(dn_data_valid), .dlast(dn_data_last));

  always #4 clock = ~clock;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] t1(input logic [7:0] b,
                                     input logic [4:0] d,
                                     input logic [2:0] f);
    return {8'h0, b, d, f, wd[7:2], 2'h1};
  endfunction : t1
  function automatic logic [31:0] t0(input logic [2:0] f);
    return {21'h0, f, wd[7:2], 2'h0};
  endfunction : t0
  task automatic nxt();
    seed = lfsr(seed);
    wd = seed;
  endtask : nxt
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic pop(ref exp_s q[$], input logic [3:0] k,
                     input logic [31:0] ad, input logic [31:0] d);
    exp_s n;
    if (q.size() == 0) begin
      chk("unexpected result", 32'h0, 32'h1);
    end else begin
      n = q.pop_front();
      chk("cmd", {28'h0, n.cmd}, {28'h0, k});
      chk("addr", n.addr, ad);
      if (n.dchk) chk("data", n.data, d);
    end
  endtask : pop
  // one transfer on either bus, claim compared at once
  task automatic go(input logic up, input logic [3:0] k,
                    input logic [31:0] ad, input logic [3:0] ctl,
                    input logic ex);
    logic got;
    if (up) up_m.xfer(k, ad, wd, wd[3:0], ctl, got);
    else dn_m.xfer(k, ad, wd, wd[3:0], ctl, got);
    chk("claim", {31'h0, ex}, {31'h0, got});
    repeat (2) @(posedge clock);
  endtask : go
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // result watcher: oldest note against each pulse
  always @(posedge clock) begin
    if (dn_fwd_valid === 1'b1) begin
      pop(dn_q, dn_fwd_cmd, dn_fwd_addr, dn_fwd_data);
    end
    if (up_fwd_valid === 1'b1) begin
      pop(up_q, up_fwd_cmd, up_fwd_addr, up_fwd_data);
    end
    if (hdr_valid === 1'b1) begin
      pop(hdr_q, hdr_byte_enable, {25'h0, hdr_write, hdr_reg_index},
          hdr_wdata);
    end
    cyc = cyc + 1;
    if (cyc == 4000) begin
      num_errors = num_errors + 1;
      test_done();
    end
  end

  // ------------
  // main sequence
  // ------------
  initial begin
    {clock, rst_n, bus_num_load} = 3'h0;
    seed = 32'h0000_7e02;
    primary_bus_in = 8'h01;
    secondary_bus_in = 8'h04;
    subordinate_bus_in = 8'h07;
    repeat (8) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clock);
    #1 bus_num_load = 1'b1;
    @(posedge clock);
    #1 bus_num_load = 1'b0;
    nxt();
    hdr_q.push_back('{4'hF, {26'h0, wd[7:2]}, wd, 1'b0});
    go(1, 4'hA, t0(3'h0), 4'hD, 1);
    nxt();
    hdr_q.push_back('{wd[3:0], {25'h0, 1'b1, wd[7:2]}, wd, 1'b1});
    go(1, 4'hB, t0(3'h0), 4'h8, 1);
    go(1, 4'hA, t0(3'h1 + wd[1:0]), 4'h8, 0);
    go(1, 4'hB, t0(3'h0), 4'h0, 0);
    $display("test header done");
    for (i = 0; i < 32; i++) begin
      nxt();
      a = t1(8'h04, i[4:0], 3'h2);
      m = i < 16;
      dn_q.push_back('{4'hB, {16'(m) << i[3:0], a[15:2], 2'h0}, wd, 1'b1});
      go(1, 4'hB, a, 4'h0, 1);
    end
    $display("test convert done");
    for (i = 3; i < 9; i++) begin
      nxt();
      a = t1(i[7:0], 5'h1F, 3'h7);
      if (i == 4) dn_q.push_back('{4'h1, 32'h0, wd, 1'b1});
      if (i > 4 && i < 8) dn_q.push_back('{4'hB, a, wd, 1'b1});
      go(1, 4'hB, a, 4'h0, i > 3 && i < 8);
    end
    nxt();
    up_q.push_back('{4'h1, 32'h0, wd, 1'b1});
    go(0, 4'hB, t1(8'h01, 5'h1F, 3'h7), 4'h1, 1);
    go(0, 4'hA, t1(8'h01, 5'h1F, 3'h7), 4'h0, 0);
    go(0, 4'hB, t1(8'h04, 5'h1F, 3'h7), 4'h0, 0);
    go(0, 4'hB, t0(3'h0), 4'h0, 0);
    $display("test special done");
    for (i = 0; i < 64; i++) begin
      nxt();
      c = i[3:0];
      a = (c[3:1] == 3'h5) ? t1(8'h09, 5'h0, 3'h0) : {wd[31:2], 2'h0};
      m = c inside {4'h2, 4'h3, 4'h6, 4'h7, [4'hC:4'hF]};
      x = m && (i[4] ^ i[5]);
      if (x && i[5]) up_q.push_back('{(c == 4'hF) ? 4'h7 : c, a, wd, c[0]});
      if (x && !i[5]) dn_q.push_back('{(c == 4'hF) ? 4'h7 : c, a, wd, c[0]});
      go(!i[5], c, a, {1'b0, i[4], 2'h0}, x);
    end
    nxt();
    a = {wd[31:2], 2'h0};
    dn_q.push_back('{4'hF, a, wd, 1'b1});
    go(1, 4'hF, a, 4'h6, 1);
    $display("test commands done");
    chk("left", 32'h0, 32'(dn_q.size() + up_q.size() + hdr_q.size()));
    test_done();
  end
endmodule : pci_bridge_config_cycle_router_tb
